// ---- core/port_line_mode_control.sv ----
// How it works
// RULE_01: power-down bit gates port clocks, set at reset
// RULE_02: datapath reset holds data-path registers at default
// RULE_03: any general reset leaves datapath reset at one
// RULE_04: port reset defaults all registers except itself
// RULE_05: effective reset is soft, hard pin, global ORed
// RULE_06: software holds reset bits at least 100ns
// RULE_07: output enable low forces line outputs low
// RULE_08: tristate floats diff outputs unless unit off
// RULE_09: monitor bit enables receive 20 dB preamp
// RULE_10: build-out shapes 225 feet, DS3 line mode only
// RULE_11: line mode selects unit, attenuator, coding
// RULE_12: framing mode selects DS3/E3 framing, default C-bit
// RULE_13: receive clock select picks shared pin function
// RULE_14: receive frame select picks enable or start-of-frame
// RULE_15: transmit clock select picks gapped or output clock
// RULE_16: transmit frame select picks enable or start-of-frame
// RULE_17: 8 kHz source picks receive or transmit clock
// RULE_18: 8 kHz reference select picks global or port
// RULE_19: loop timing clocks transmitter from receive side
// RULE_20: rate-adapter bit excludes adapter clocks from transmit
// RULE_21: receive timing select picks input or output clocks
// RULE_22: transmit timing select sets transmit pin clock reference
// RULE_23: transmit timing zero output clocks, one input
// RULE_24: reserved bits read zero, writes ignored
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module port_line_mode_control (
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    // hardware and global reset requests, zero-suppress disable and loopback status
    input  wire logic                      hwResetn,
    input  wire logic                      globalReset,
    input  wire logic                      txZeroSuppressDisable,
    input  wire logic                      loopbackActive,
    // ahb-lite slave
    input  wire logic                      hsel,
    input  wire logic [9:0]                haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    // port control outputs
    output logic                           portClockEnable,
    output logic                           datapathResetActive,
    output logic                           portResetActive,
    output logic                           txLineOutputEnable,
    output plm_pkg::plm_line_cfg_s         lineCfg,
    output plm_pkg::plm_frame_cfg_s        frameCfg,
    output plm_pkg::plm_clock_cfg_s        clockCfg,
    output logic      [2:0]                framingMode,
    output plm_pkg::plm_state_e            portState
);
    import plm_pkg::*;

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [15:0]        resetPower;        // power down and reset bits
    logic [15:0]        lineControl;       // line interface settings
    logic [15:0]        clockSelect;       // clocking selects
    logic [15:0]        next_resetPower;
    logic [15:0]        next_lineControl;
    logic [15:0]        next_clockSelect;

    // bus data phase state
    logic               wrPending;         // write data phase due
    logic [7:0]         wrAddr;            // latched write address
    logic [31:0]        next_hrdata;
    logic               next_wrPending;
    logic [7:0]         next_wrAddr;

    // effective port reset term
    logic               effReset;
    logic               addrPhase;
    logic [15:0]        readWord;
    logic [15:0]        wdata;
    logic [7:0]         regIndex;          // word index taken from the byte address

    // registered outputs next values
    logic               next_portClockEnable;
    logic               next_datapathResetActive;
    logic               next_portResetActive;
    logic               next_txLineOutputEnable;
    plm_line_cfg_s      next_lineCfg;
    plm_frame_cfg_s     next_frameCfg;
    plm_clock_cfg_s     next_clockCfg;
    logic [2:0]         next_framingMode;
    plm_state_e         next_portState;
    logic [2:0]         lm;
    logic [2:0]         fm;

    // ****************************************************************
    // effective reset and bus decode
    // ****************************************************************
    // soft port reset ORed with inverted hardware pin and global reset
    assign effReset  = resetPower[BIT_PORT_RESET] | ~hwResetn | globalReset; // RULE_05
    assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);
    assign wdata     = hwdata[15:0];
    assign regIndex  = haddr[ADDR_SHIFT +: 8];

    // read mux, unmapped addresses read zero
    always_comb begin
        case (regIndex)
            ADDR_PORT_RESET_POWER_CONTROL:  readWord = resetPower & MASK_RESET_POWER;   // RULE_24
            ADDR_PORT_LINE_CONTROL:         readWord = lineControl & MASK_LINE_CONTROL;
            ADDR_PORT_CLOCK_SELECT_CONTROL: readWord = clockSelect & MASK_CLOCK_SELECT;
            default:                        readWord = 16'h0000;
        endcase
    end

    // ****************************************************************
    // register next values
    // ****************************************************************
    always_comb begin
        next_resetPower  = resetPower;
        next_lineControl = lineControl;
        next_clockSelect = clockSelect;
        next_wrPending   = 1'b0;
        next_wrAddr      = wrAddr;
        next_hrdata      = hrdata;
        // address phase: capture write target or load read data
        if (addrPhase) begin
            next_wrPending = hwrite;
            next_wrAddr    = regIndex;
            if (!hwrite) begin
                next_hrdata = {16'h0000, readWord};
            end
        end
        // data phase write, reserved bits masked off
        if (wrPending) begin
            case (wrAddr)
                ADDR_PORT_RESET_POWER_CONTROL: begin
                    next_resetPower = wdata & MASK_RESET_POWER; // RULE_24
                end
                ADDR_PORT_LINE_CONTROL: begin
                    next_lineControl = wdata & MASK_LINE_CONTROL;
                end
                ADDR_PORT_CLOCK_SELECT_CONTROL: begin
                    next_clockSelect = wdata & MASK_CLOCK_SELECT;
                end
                default: begin
                    next_wrAddr = wrAddr;
                end
            endcase
        end
        // hard or global reset, or soft reset for all but itself
        if (effReset) begin
            next_lineControl = RESET_LINE_CONTROL; // RULE_04
            next_clockSelect = RESET_CLOCK_SELECT;
            next_resetPower  = {RESET_RESET_POWER[15:1], next_resetPower[BIT_PORT_RESET]}; // RULE_04
            next_resetPower[BIT_DATAPATH_RESET] = 1'b1; // RULE_03
            if (!hwResetn || globalReset) begin
                next_resetPower[BIT_PORT_RESET] = 1'b0;
            end
        end
    end

    // register stage
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            resetPower  <= RESET_RESET_POWER; // RULE_01
            lineControl <= RESET_LINE_CONTROL;
            clockSelect <= RESET_CLOCK_SELECT;
            wrPending   <= 1'b0;
            wrAddr      <= 8'h00;
            hrdata      <= 32'h0000_0000;
        end else begin
            resetPower  <= next_resetPower;
            lineControl <= next_lineControl;
            clockSelect <= next_clockSelect;
            wrPending   <= next_wrPending;
            wrAddr      <= next_wrAddr;
            hrdata      <= next_hrdata;
        end
    end

    // ****************************************************************
    // decode of control fields
    // ****************************************************************
    always_comb begin
        lm = lineControl[POS_LINE_MODE +: 3];
        fm = lineControl[POS_FRAMING_MODE +: 3];
        // power gating: clocks stop while powered down
        next_portClockEnable     = ~resetPower[BIT_POWER_DOWN]; // RULE_01
        // software keeps these high at least the minimum width
        next_datapathResetActive = resetPower[BIT_DATAPATH_RESET] | effReset; // RULE_02 RULE_06
        next_portResetActive     = effReset; // RULE_04
        next_txLineOutputEnable  = lineControl[BIT_TX_LINE_OUTPUT_ENABLE]; // RULE_07
        // line mode table
        next_lineCfg = '0;
        next_lineCfg.unipolar  = lm[2]; // RULE_11
        next_lineCfg.amiCoding = txZeroSuppressDisable & ~lm[2];
        case (lm)
            LINE_MODE_LIU: begin
                next_lineCfg.lineInterfaceUnitOn = 1'b1;
            end
            LINE_MODE_JA_TX: begin
                next_lineCfg.lineInterfaceUnitOn = 1'b1;
                next_lineCfg.jitterAttenuatorTx  = 1'b1;
            end
            LINE_MODE_JA_RX: begin
                next_lineCfg.lineInterfaceUnitOn = 1'b1;
                next_lineCfg.jitterAttenuatorRx  = 1'b1;
            end
            default: begin
                next_lineCfg.lineInterfaceUnitOn = 1'b0;
            end
        endcase
        // tristate only meaningful with the line unit powered
        next_lineCfg.txDiffFloat = lineControl[BIT_TX_LINE_TRISTATE] & next_lineCfg.lineInterfaceUnitOn; // RULE_08
        next_lineCfg.rxPreampOn  = lineControl[BIT_RX_MONITOR_PREAMP]; // RULE_09
        // framing table, decoded first so build-out sees this cycle's value
        next_framingMode       = fm; // RULE_12
        next_frameCfg.isE3     = (fm == FRAME_E3_G751) | (fm == FRAME_E3_G832) | (fm[2:1] == 2'b11);
        next_frameCfg.clearChannel = fm[2];
        next_frameCfg.cbit     = (fm == FRAME_DS3_CBIT);
        next_frameCfg.g832     = (fm == FRAME_E3_G832);
        // build-out only in DS3 framing with line unit on
        next_lineCfg.txBuildOutActive = lineControl[BIT_TX_BUILD_OUT] & next_lineCfg.lineInterfaceUnitOn
                                        & ~next_frameCfg.isE3; // RULE_10
        // pin function selects
        next_clockCfg.rxClockOutSel = clockSelect[BIT_RX_CLOCK_OUT_SELECT]; // RULE_13
        next_clockCfg.rxFrameOutSel = clockSelect[BIT_RX_FRAME_OUT_SELECT]; // RULE_14
        next_clockCfg.txClockOutSel = clockSelect[BIT_TX_CLOCK_OUT_SELECT]; // RULE_15
        next_clockCfg.txFrameOutSel = clockSelect[BIT_TX_FRAME_OUT_SELECT]; // RULE_16
        // 8 kHz source: 1x valid, low bit picks transmit
        next_clockCfg.port8kValid  = clockSelect[POS_PORT_8K_SOURCE_SELECT + 1]; // RULE_17
        next_clockCfg.port8kFromTx = clockSelect[POS_PORT_8K_SOURCE_SELECT];
        next_clockCfg.port8kLocal  = clockSelect[BIT_PORT_8K_REFERENCE]; // RULE_18
        // transmit clock source selection
        next_clockCfg.txClockFromRx = clockSelect[BIT_LOOP_TIMING_ENABLE]; // RULE_19
        next_clockCfg.txClockFromAdapter = ~clockSelect[BIT_RATE_ADAPTER_CLK_DIS]
                                           & ~loopbackActive; // RULE_20
        next_clockCfg.rxTimingInput = clockSelect[BIT_RX_FRAMER_TIMING_SELECT]; // RULE_21
        next_clockCfg.txTimingInput = clockSelect[BIT_TX_FRAMER_TIMING_SELECT]; // RULE_22 RULE_23
        // port state summary
        if (resetPower[BIT_POWER_DOWN]) begin
            next_portState = ST_POWERED;
        end else if (next_datapathResetActive) begin
            next_portState = ST_HELD;
        end else begin
            next_portState = ST_RUN;
        end
    end

    // output register stage
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            portClockEnable     <= 1'b0;
            datapathResetActive <= 1'b1;
            portResetActive     <= 1'b0;
            txLineOutputEnable  <= 1'b0;
            lineCfg             <= '0;
            frameCfg            <= '0;
            clockCfg            <= '0;
            framingMode         <= 3'h0;
            portState           <= ST_POWERED;
            hreadyout           <= 1'b1;
            hresp               <= HRESP_OKAY;
        end else begin
            portClockEnable     <= next_portClockEnable;
            datapathResetActive <= next_datapathResetActive;
            portResetActive     <= next_portResetActive;
            txLineOutputEnable  <= next_txLineOutputEnable;
            lineCfg             <= next_lineCfg;
            frameCfg            <= next_frameCfg;
            clockCfg            <= next_clockCfg;
            framingMode         <= next_framingMode;
            portState           <= next_portState;
            hreadyout           <= 1'b1;
            hresp               <= HRESP_OKAY;
        end
    end

endmodule

`default_nettype wire

// ---- include/plm_pkg.sv ----
// ****************************************************************
// port line mode control package
// ****************************************************************
package plm_pkg;

    // register indices, the byte address on the bus is the index times four
    localparam logic [7:0] ADDR_PORT_RESET_POWER_CONTROL  = 8'h40;
    localparam logic [7:0] ADDR_PORT_LINE_CONTROL         = 8'h42;
    localparam logic [7:0] ADDR_PORT_CLOCK_SELECT_CONTROL = 8'h44;
    localparam int         ADDR_SHIFT                     = 2;

    // reset values
    localparam logic [15:0] RESET_RESET_POWER  = 16'h0006;
    localparam logic [15:0] RESET_LINE_CONTROL = 16'h0000;
    localparam logic [15:0] RESET_CLOCK_SELECT = 16'h0000;

    // writable bit masks, everything else reads zero
    localparam logic [15:0] MASK_RESET_POWER  = 16'h0007;
    localparam logic [15:0] MASK_LINE_CONTROL = 16'hF738;
    localparam logic [15:0] MASK_CLOCK_SELECT = 16'h36FE;

    // reset and power field positions
    localparam int BIT_PORT_RESET     = 0;
    localparam int BIT_DATAPATH_RESET = 1;
    localparam int BIT_POWER_DOWN     = 2;

    // line control field positions
    localparam int BIT_TX_LINE_OUTPUT_ENABLE = 15;
    localparam int BIT_TX_LINE_TRISTATE      = 14;
    localparam int BIT_RX_MONITOR_PREAMP     = 13;
    localparam int BIT_TX_BUILD_OUT          = 12;
    localparam int POS_LINE_MODE             = 8;
    localparam int POS_FRAMING_MODE          = 3;

    // clock select field positions
    localparam int BIT_RX_CLOCK_OUT_SELECT     = 13;
    localparam int BIT_RX_FRAME_OUT_SELECT     = 12;
    localparam int BIT_TX_CLOCK_OUT_SELECT     = 10;
    localparam int BIT_TX_FRAME_OUT_SELECT     = 9;
    localparam int POS_PORT_8K_SOURCE_SELECT   = 6;
    localparam int BIT_PORT_8K_REFERENCE       = 5;
    localparam int BIT_LOOP_TIMING_ENABLE      = 4;
    localparam int BIT_RATE_ADAPTER_CLK_DIS    = 3;
    localparam int BIT_RX_FRAMER_TIMING_SELECT = 2;
    localparam int BIT_TX_FRAMER_TIMING_SELECT = 1;

    // line mode codes
    localparam logic [2:0] LINE_MODE_OFF     = 3'h0;
    localparam logic [2:0] LINE_MODE_LIU     = 3'h1;
    localparam logic [2:0] LINE_MODE_JA_TX   = 3'h2;
    localparam logic [2:0] LINE_MODE_JA_RX   = 3'h3;

    // framing mode codes
    localparam logic [2:0] FRAME_DS3_CBIT  = 3'h0;
    localparam logic [2:0] FRAME_DS3_M13   = 3'h1;
    localparam logic [2:0] FRAME_E3_G751   = 3'h2;
    localparam logic [2:0] FRAME_E3_G832   = 3'h3;
    localparam logic [2:0] FRAME_DS3_CLEAR = 3'h4;

    // software reset minimum width
    localparam int RESET_MIN_NS    = 100;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ahb transfer type and response
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    // decoded line interface configuration
    typedef struct packed {
        logic       lineInterfaceUnitOn;
        logic       jitterAttenuatorTx;
        logic       jitterAttenuatorRx;
        logic       unipolar;
        logic       amiCoding;
        logic       txBuildOutActive;
        logic       rxPreampOn;
        logic       txDiffFloat;
    } plm_line_cfg_s;

    // decoded framing configuration
    typedef struct packed {
        logic       isE3;
        logic       clearChannel;
        logic       cbit;
        logic       g832;
    } plm_frame_cfg_s;

    // decoded clocking and pin function selects
    typedef struct packed {
        logic       rxClockOutSel;
        logic       rxFrameOutSel;
        logic       txClockOutSel;
        logic       txFrameOutSel;
        logic       port8kFromTx;
        logic       port8kValid;
        logic       port8kLocal;
        logic       txClockFromRx;
        logic       txClockFromAdapter;
        logic       rxTimingInput;
        logic       txTimingInput;
    } plm_clock_cfg_s;

    // port state
    typedef enum logic [2:0] {
        ST_HELD    = 3'b001,
        ST_RUN     = 3'b010,
        ST_POWERED = 3'b100
    } plm_state_e;

endpackage

// ---- test/plm_checker_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none

module plm_checker (
    // clock and reset
    input wire logic                   core_clk,
    input wire logic                   rstn,
    input wire logic                   hwResetn,
    input wire logic                   globalReset,
    // bus
    input wire logic                   hsel,
    input wire logic [9:0]             haddr,
    input wire logic [1:0]             htrans,
    input wire logic                   hwrite,
    input wire logic                   hready,
    input wire logic [31:0]            hrdata,
    input wire logic                   hreadyout,
    input wire logic                   hresp,
    // port controls
    input wire logic                   portClockEnable,
    input wire logic                   datapathResetActive,
    input wire logic                   portResetActive,
    input wire plm_pkg::plm_line_cfg_s lineCfg,
    input wire plm_pkg::plm_frame_cfg_s frameCfg,
    input wire logic [2:0]             framingMode,
    input wire plm_pkg::plm_state_e    portState
);
    import plm_pkg::*;

    // ****
    // clocking and step sequences
    // ****
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // a read taken on the bus
    sequence s_read_req;
        hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    endsequence

    // a pin or global reset request
    sequence s_hw_reset;
        !hwResetn || globalReset;
    endsequence

    // ****
    // assertions
    // ****
    a_reset_or_terms: assert property (s_hw_reset |=> portResetActive)
        else $error("effective reset not raised");
    a_reset_defaults: assert property (s_hw_reset [*6] |-> !portClockEnable && datapathResetActive)
        else $error("port not powered down and held under reset");
    a_datapath_held: assert property (portResetActive |-> datapathResetActive)
        else $error("data path free during port reset");
    a_state_powered: assert property (!portClockEnable == (portState == ST_POWERED))
        else $error("power state and clock enable disagree");
    a_state_held: assert property (portClockEnable && datapathResetActive |-> portState == ST_HELD)
        else $error("port not held");
    a_build_out_gate: assert property (lineCfg.txBuildOutActive |-> lineCfg.lineInterfaceUnitOn && !frameCfg.isE3)
        else $error("build-out outside line unit mode");
    a_tristate_gate: assert property (lineCfg.txDiffFloat |-> lineCfg.lineInterfaceUnitOn)
        else $error("float with line unit off");
    a_unipolar_off: assert property (lineCfg.unipolar |-> !lineCfg.lineInterfaceUnitOn && !lineCfg.jitterAttenuatorRx)
        else $error("unipolar with line unit on");
    a_frame_decode: assert property (frameCfg.isE3 == framingMode[1] && frameCfg.clearChannel == framingMode[2])
        else $error("framing decode wrong");
    a_reserved_zero: assert property (s_read_req |=> hreadyout && hresp == HRESP_OKAY && hrdata[31:16] == 16'h0000
        && ($past(haddr[9:2]) != ADDR_PORT_RESET_POWER_CONTROL || hrdata[15:3] == 13'h0000))
        else $error("reserved read bits not zero");
endmodule

bind port_line_mode_control plm_checker u_plm_checker (
    .core_clk(core_clk), .rstn(rstn), .hwResetn(hwResetn), .globalReset(globalReset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .portClockEnable(portClockEnable),
    .datapathResetActive(datapathResetActive), .portResetActive(portResetActive),
    .lineCfg(lineCfg), .frameCfg(frameCfg), .framingMode(framingMode), .portState(portState)
);

`default_nettype wire

// ---- test/port_line_mode_control_test.sv ----
`timescale 1ns/100ps
`default_nettype none

module port_line_mode_control_test;
    import plm_pkg::*;

    // ****
    // signals and model state
    // ****
    localparam logic [9:0] aPwr  = {ADDR_PORT_RESET_POWER_CONTROL, 2'b00};
    localparam logic [9:0] aLine = {ADDR_PORT_LINE_CONTROL, 2'b00};
    localparam logic [9:0] aClk  = {ADDR_PORT_CLOCK_SELECT_CONTROL, 2'b00};
    logic           core_clk    = 1'b0;
    logic           rstn        = 1'b0;
    logic           hwResetn    = 1'b1;
    logic           globalReset = 1'b0;
    logic           txZsd       = 1'b0;
    logic           loopback    = 1'b0;
    logic           hsel        = 1'b0;
    logic [9:0]     haddr       = 10'h000;
    logic [1:0]     htrans      = 2'h0;
    logic           hwrite      = 1'b0;
    logic [31:0]    hwdata      = 32'h00000000;
    logic [31:0]    hrdata;
    logic           hreadyout;
    logic           hresp;
    logic           clkEn, dpAct, prAct, txEn;
    plm_line_cfg_s  lineCfg;
    plm_frame_cfg_s frameCfg;
    plm_clock_cfg_s clockCfg;
    logic [2:0]     framingMode;
    plm_state_e     portState;
    int             m40 = 6, m42 = 0, m44 = 0; // model registers
    int             seed = 92;
    int             nErrors = 0, totalChecks = 0;

    // free-running clock
    always #5 core_clk = ~core_clk;

    port_line_mode_control dut (
        .core_clk(core_clk), .rstn(rstn), .hwResetn(hwResetn), .globalReset(globalReset),
        .txZeroSuppressDisable(txZsd), .loopbackActive(loopback), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .portClockEnable(clkEn),
        .datapathResetActive(dpAct), .portResetActive(prAct), .txLineOutputEnable(txEn),
        .lineCfg(lineCfg), .frameCfg(frameCfg), .clockCfg(clockCfg), .framingMode(framingMode),
        .portState(portState)
    );

    // ****
    // helpers
    // ****
    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // effective reset forcing in the model
    task automatic modelForce();
        if (!hwResetn || globalReset) m40 = m40 & 6;
        if (!hwResetn || globalReset || m40[0]) begin
            m40 = m40 | 6;
            m42 = 0;
            m44 = 0;
        end
    endtask

    function automatic logic [31:0] modelRead(input logic [9:0] a);
        if (a == aPwr) return m40;
        if (a == aLine) return m42;
        if (a == aClk) return m44;
        return 0;
    endfunction

    // bounded wait for hready at the next edges
    task automatic waitReady();
        int n;
        n = 0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 50) begin
            nErrors++;
            $display("BAD %0t bus wait ran out", $time);
            tallyAndFinish();
        end
    endtask

    // one single ahb transfer, entered just after a rising edge
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d, output logic [31:0] r);
        logic held;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        waitReady();
        htrans <= 2'h0;
        hwdata <= d;
        waitReady();
        r = hrdata;
        // the write lands under the effective reset seen in its data phase
        held = !hwResetn || globalReset || m40[0];
        if (wr && a == aPwr) m40 = d & MASK_RESET_POWER;
        if (wr && a == aLine) m42 = d & MASK_LINE_CONTROL;
        if (wr && a == aClk) m44 = d & MASK_CLOCK_SELECT;
        if (held) m40 = m40 | 6;
        modelForce();
    endtask

    task automatic wrt(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rdchk(input logic [9:0] a);
        logic [31:0] r;
        bus(1'b0, a, 32'h00000000, r);
        check(r, modelRead(a));
    endtask

    // compare every decoded output with the model once settled
    task automatic settleCheck();
        logic [15:0] l;
        logic [15:0] c;
        logic [2:0]  lm;
        logic [2:0]  fm;
        logic        eff;
        logic        line_interface_unit;
        repeat (4) @(posedge core_clk);
        l = m42[15:0];
        c = m44[15:0];
        lm = l[10:8];
        fm = l[5:3];
        eff = !hwResetn || globalReset || m40[0];
        line_interface_unit = !lm[2] && lm != 3'h0;
        check(clkEn, !m40[2]);
        check(dpAct, m40[1] || eff);
        check(prAct, eff);
        check(txEn, l[15]);
        check(lineCfg, {line_interface_unit, lm == 3'h2, lm == 3'h3, lm[2], txZsd & ~lm[2], l[12] & line_interface_unit & ~fm[1], l[13], l[14] & line_interface_unit});
        check(frameCfg, {fm[1], fm[2], fm == 3'h0, fm == 3'h3});
        check(framingMode, fm);
        check(clockCfg[10:7], {c[13:12], c[10:9]});
        check(clockCfg[6:3], {c[6], c[7], c[5:4]});
        check(clockCfg[2:0], {~(c[3] | loopback), c[2:1]});
        check(portState, m40[2] ? ST_POWERED : (m40[1] || eff) ? ST_HELD : ST_RUN);
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        rdchk(aPwr);
        rdchk(aLine);
        rdchk(10'h120);
        settleCheck();
        $display("reset values done");
        wrt(aPwr, 32'hFFFFFFF8);
        wrt(aClk, 32'hFFFFFFFF);
        wrt(10'h120, 32'hFFFFFFFF);
        rdchk(aPwr);
        rdchk(aClk);
        rdchk(10'h120);
        for (int i = 0; i < 8; i++) begin
            wrt(aLine, 32'hFFFFF000 | 32'(i << 8) | 32'(i << 3));
            rdchk(aLine);
            settleCheck();
        end
        $display("mode codes done");
        for (int i = 0; i < 40; i++) begin
            txZsd <= 1'($random(seed));
            loopback <= 1'($random(seed));
            wrt(aLine, $random(seed));
            wrt(aClk, $random(seed));
            wrt(aPwr, $random(seed) & 32'h6);
            rdchk(aLine);
            rdchk(aClk);
            settleCheck();
        end
        $display("random settings done");
        wrt(aPwr, 32'h1);
        repeat (RESET_MIN_CYCLES) @(posedge core_clk);
        wrt(aLine, 32'hF738);
        rdchk(aPwr);
        rdchk(aLine);
        settleCheck();
        // the write ending the port reset still sees it, so bits 2 and 1 stay set
        wrt(aPwr, 32'h0);
        rdchk(aPwr);
        settleCheck();
        wrt(aPwr, 32'h0);
        rdchk(aPwr);
        settleCheck();
        $display("soft reset done");
        for (int k = 0; k < 2; k++) begin
            wrt(aPwr, 32'h1);
            hwResetn <= (k != 0);
            globalReset <= (k != 0);
            repeat (RESET_MIN_CYCLES) @(posedge core_clk);
            modelForce();
            settleCheck();
            rdchk(aPwr);
            hwResetn <= 1'b1;
            globalReset <= 1'b0;
            @(posedge core_clk);
            settleCheck();
        end
        $display("pin and global reset done");
        tallyAndFinish();
    end
endmodule

`default_nettype wire
